// file: rtl/iftcr_pkg.sv
/*
 * Constants for the IF transceiver control register bank: serial word layout,
 * field positions inside the 21-bit shift register, reset defaults and limits.
 * Assumes it is referenced by scoped name only, never imported.
 */
package iftcr_pkg;

    // ----------------------------------------------------------------------
    // serial word framing
    // ----------------------------------------------------------------------
    localparam int unsigned WORD_BITS    = 21;
    localparam int unsigned ADDR_MSB     = 20;          // first bit shifted in
    localparam int unsigned ADDR_BITS    = 4;
    localparam logic [3:0]  CHIP_ADDR    = 4'he;        // address 1110
    localparam int unsigned SEL_POS      = 16;          // word select bit
    localparam logic        SEL_SYNTH    = 1'h0;
    localparam logic        SEL_RECEIVE  = 1'h1;

    // ----------------------------------------------------------------------
    // first word fields (select = 0)
    // ----------------------------------------------------------------------
    localparam int unsigned RATIO_MSB    = 15;          // main ratio, msb first
    localparam int unsigned RATIO_BITS   = 9;
    localparam int unsigned REF_MSB      = 6;           // first ref bit, then second
    localparam int unsigned PUMP_B0_POS  = 4;           // weight-1 pump bit
    localparam int unsigned PUMP_B1_POS  = 3;
    localparam int unsigned PUMP_B2_POS  = 2;           // weight-4 pump bit
    localparam int unsigned LOCK_MSB     = 1;           // first lock test bit, then second

    // ----------------------------------------------------------------------
    // second word fields (select = 1)
    // ----------------------------------------------------------------------
    localparam int unsigned PIN_A_POS    = 15;
    localparam int unsigned PIN_B_POS    = 14;
    localparam int unsigned QTRIM_MSB    = 13;          // polarity then 3 magnitude bits
    localparam int unsigned ITRIM_MSB    = 9;
    localparam int unsigned ATTEN_POS    = 5;
    localparam int unsigned FTEST_POS    = 4;
    localparam int unsigned DLOOP_HI_POS = 3;
    localparam int unsigned DLOOP_LO_POS = 2;
    localparam int unsigned RC_POS       = 1;
    localparam int unsigned GYR_POS      = 0;

    // ----------------------------------------------------------------------
    // limits and reset defaults
    // ----------------------------------------------------------------------
    localparam logic [8:0]  RATIO_MIN    = 9'h040;      // 64
    localparam logic [8:0]  RATIO_RST    = 9'h190;      // 400
    localparam logic [1:0]  REF_RST      = 2'h0;        // divide by 13
    localparam logic [2:0]  PUMP_RST     = 3'h7;        // maximum current
    localparam logic [1:0]  LOCK_RST     = 2'h0;        // normal lock output
    localparam logic [1:0]  PINS_RST     = 2'h3;        // both logic outputs high
    localparam logic [3:0]  TRIM_RST     = 4'h0;
    localparam logic [5:0]  MODE_RST     = 6'h00;

    // duty-cycle loop modes as {hi, lo}
    localparam logic [1:0]  DLOOP_ON     = 2'h0;
    localparam logic [1:0]  DLOOP_MEDIUM = 2'h1;
    localparam logic [1:0]  DLOOP_OFF    = 2'h2;
    localparam logic [1:0]  DLOOP_FINE   = 2'h3;

endpackage : iftcr_pkg

// file: rtl/iftcr_pin_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one asynchronous pin.
 * Assumes clk_in is the block clock and rst_n_in a synchronous active-low reset.
 */
`timescale 1ns/1ns

module iftcr_pin_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // asynchronous pin and filtered level
    input  wire logic pin_in,
    output logic      level_out
);

    typedef struct packed {
        logic meta;     // first stage, read only by the second
        logic s2;
        logic s3;
        logic level;
    } iftcr_sync_t;

    iftcr_sync_t q;
    iftcr_sync_t d;

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    // the level only moves once stages two and three agree, so a glitch
    // shorter than a clock never reaches the shift logic
    always_comb begin
        d      = q;
        d.meta = pin_in;
        d.s2   = q.meta;
        d.s3   = q.s2;
        if (q.s2 == q.s3) begin
            d.level = q.s3;
        end
    end

    // state register
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level_out = q.level;

endmodule : iftcr_pin_sync

// file: rtl/iftcr_ctrl_regs.sv
/*
 * Control register bank of an IF I/Q transceiver, loaded over a three-wire
 * clock / strobe / data serial input, plus power-down gating of the receive,
 * transmit and synthesizer sections.
 * Assumes all serial and power pins are asynchronous to clk_in (100 MHz) and
 * that rst_n_in is asserted when the digital supply comes up.
 */
`timescale 1ns/1ns

module iftcr_ctrl_regs (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // serial programming pins
    input  wire logic       ser_clock_in,
    input  wire logic       ser_strobe_in,
    input  wire logic       ser_data_in,
    // power pins
    input  wire logic       receive_power_on_in,
    input  wire logic       transmit_power_down_n_in,
    input  wire logic       synth_power_on_in,
    // programmable logic output pins
    output logic            pin_a_level_out,
    output logic            pin_b_level_out,
    // synthesizer settings
    output logic [8:0]      main_divider_ratio_out,
    output logic [1:0]      reference_divide_select_out,
    output logic [2:0]      pump_current_select_out,
    output logic [1:0]      lock_pin_test_select_out,
    // offset trims
    output logic            inphase_trim_polarity_out,
    output logic [2:0]      inphase_trim_magnitude_out,
    output logic            quad_trim_polarity_out,
    output logic [2:0]      quad_trim_magnitude_out,
    // receive mode
    output logic            if_atten_select_out,
    output logic            factory_test_bit_out,
    output logic [1:0]      duty_cycle_loop_mode_out,
    output logic            rc_cutoff_select_out,
    output logic            gyrator_resistor_select_out,
    // section power controls
    output logic            receive_enable_out,
    output logic            transmit_enable_out,
    output logic            synth_dividers_enable_out,
    output logic            phase_detector_reset_out,
    output logic            pump_current_ref_connect_out
);

    // ----------------------------------------------------------------------
    // state
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic        clk_prev;
        logic        stb_prev;
        logic [20:0] shift;
        logic [8:0]  ratio;
        logic [1:0]  ref_sel;
        logic [2:0]  pump;
        logic [1:0]  lock_test;
        logic [1:0]  pins;
        logic [3:0]  qtrim;
        logic [3:0]  itrim;
        logic        atten;
        logic        ftest;
        logic [1:0]  dloop;
        logic        rc;
        logic        gyr;
        logic        rx_en;
        logic        tx_en;
        logic        syn_en;
    } iftcr_state_t;

    iftcr_state_t q;
    iftcr_state_t d;

    logic clk_lvl;
    logic stb_lvl;
    logic dat_lvl;
    logic rx_lvl;
    logic tx_on_pin;
    logic tx_on_lvl;
    logic syn_lvl;

    // ----------------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------------
    // data passes the same three stages as the clock, so the sampled bit
    // lines up with the sampled clock edge
    iftcr_pin_sync u_sync_clk (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (ser_clock_in),
        .level_out (clk_lvl)
    );

    iftcr_pin_sync u_sync_stb (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (ser_strobe_in),
        .level_out (stb_lvl)
    );

    iftcr_pin_sync u_sync_dat (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (ser_data_in),
        .level_out (dat_lvl)
    );

    iftcr_pin_sync u_sync_rx (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (receive_power_on_in),
        .level_out (rx_lvl)
    );

    // transmit pin inverted ahead of its synchroniser, so the zero that the
    // chain holds after reset reads as transmitter off, never a brief enable
    assign tx_on_pin = !transmit_power_down_n_in;

    iftcr_pin_sync u_sync_tx (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (tx_on_pin),
        .level_out (tx_on_lvl)
    );

    iftcr_pin_sync u_sync_syn (
        .clk_in    (clk_in),
        .rst_n_in  (rst_n_in),
        .pin_in    (synth_power_on_in),
        .level_out (syn_lvl)
    );

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        d          = q;
        d.clk_prev = clk_lvl;
        d.stb_prev = stb_lvl;

        // shift on a rising serial clock only while strobe is low
        if (!stb_lvl && clk_lvl && !q.clk_prev) begin
            d.shift = {q.shift[19:0], dat_lvl};
        end

        // commit the whole word in one cycle on the strobe rising edge;
        // loading does not depend on synth power, so it works powered down
        if (stb_lvl && !q.stb_prev
            && q.shift[iftcr_pkg::ADDR_MSB -: iftcr_pkg::ADDR_BITS]
               == iftcr_pkg::CHIP_ADDR) begin
            if (q.shift[iftcr_pkg::SEL_POS] == iftcr_pkg::SEL_SYNTH) begin
                // ratios below 64 are not allowed; clamp rather than run
                // the divider outside its range
                if (q.shift[iftcr_pkg::RATIO_MSB -: iftcr_pkg::RATIO_BITS]
                    < iftcr_pkg::RATIO_MIN) begin
                    d.ratio = iftcr_pkg::RATIO_MIN;
                end else begin
                    d.ratio = q.shift[iftcr_pkg::RATIO_MSB -: iftcr_pkg::RATIO_BITS];
                end
                d.ref_sel   = q.shift[iftcr_pkg::REF_MSB -: 2];
                d.pump      = {q.shift[iftcr_pkg::PUMP_B2_POS],
                               q.shift[iftcr_pkg::PUMP_B1_POS],
                               q.shift[iftcr_pkg::PUMP_B0_POS]};
                d.lock_test = q.shift[iftcr_pkg::LOCK_MSB -: 2];
            end else begin
                d.pins  = {q.shift[iftcr_pkg::PIN_B_POS],
                           q.shift[iftcr_pkg::PIN_A_POS]};
                d.qtrim = q.shift[iftcr_pkg::QTRIM_MSB -: 4];
                d.itrim = q.shift[iftcr_pkg::ITRIM_MSB -: 4];
                d.atten = q.shift[iftcr_pkg::ATTEN_POS];
                // stored as written; software is expected to keep it zero
                d.ftest = q.shift[iftcr_pkg::FTEST_POS];
                d.dloop = {q.shift[iftcr_pkg::DLOOP_HI_POS],
                           q.shift[iftcr_pkg::DLOOP_LO_POS]};
                d.rc    = q.shift[iftcr_pkg::RC_POS];
                d.gyr   = q.shift[iftcr_pkg::GYR_POS];
            end
        end

        // section power follows the filtered pins
        d.rx_en  = rx_lvl;
        d.tx_en  = tx_on_lvl;
        d.syn_en = syn_lvl;
    end

    // ----------------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------------
    // reset stands for the supply-up reset; power pins never clear settings
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q           <= '0;
            q.ratio     <= iftcr_pkg::RATIO_RST;
            q.ref_sel   <= iftcr_pkg::REF_RST;
            q.pump      <= iftcr_pkg::PUMP_RST;
            q.lock_test <= iftcr_pkg::LOCK_RST;
            q.pins      <= iftcr_pkg::PINS_RST;
            q.qtrim     <= iftcr_pkg::TRIM_RST;
            q.itrim     <= iftcr_pkg::TRIM_RST;
            {q.atten, q.ftest, q.dloop, q.rc, q.gyr} <= iftcr_pkg::MODE_RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------------
    // outputs, all from the state register, phase_detector_reset_out through an inverter
    // ----------------------------------------------------------------------
    // logic pins
    assign pin_a_level_out = q.pins[0];
    assign pin_b_level_out = q.pins[1];

    // synthesizer settings
    assign main_divider_ratio_out      = q.ratio;
    assign reference_divide_select_out = q.ref_sel;
    assign pump_current_select_out     = q.pump;
    assign lock_pin_test_select_out    = q.lock_test;

    // offset trims
    assign inphase_trim_polarity_out  = q.itrim[3];
    assign inphase_trim_magnitude_out = q.itrim[2:0];
    assign quad_trim_polarity_out     = q.qtrim[3];
    assign quad_trim_magnitude_out    = q.qtrim[2:0];

    // receive mode
    assign if_atten_select_out         = q.atten;
    assign factory_test_bit_out        = q.ftest;
    assign duty_cycle_loop_mode_out    = q.dloop;
    assign rc_cutoff_select_out        = q.rc;
    assign gyrator_resistor_select_out = q.gyr;

    // section power; the synthesizer pin also feeds the quadrature divider,
    // but the block does not override rx or tx when it is low
    assign receive_enable_out           = q.rx_en;
    assign transmit_enable_out          = q.tx_en;
    assign synth_dividers_enable_out    = q.syn_en;
    assign phase_detector_reset_out     = !q.syn_en;
    assign pump_current_ref_connect_out = q.syn_en;

endmodule : iftcr_ctrl_regs

// file: tb/iftcr_ctrl_regs_assertions.sv
/*
 * Concurrent checks on the control register bank: power gating and word commit timing.
 * Assumes it is bound to iftcr_ctrl_regs, whose ports carry the same names.
 */
`timescale 1ns/1ns

module iftcr_ctrl_regs_assertions (
    // clock and reset
    input wire logic       clk_in,
    input wire logic       rst_n_in,
    // pins
    input wire logic       ser_strobe_in,
    input wire logic       receive_power_on_in,
    input wire logic       transmit_power_down_n_in,
    input wire logic       synth_power_on_in,
    // outputs
    input wire logic       pin_a_level_out,
    input wire logic       pin_b_level_out,
    input wire logic [8:0] main_divider_ratio_out,
    input wire logic [2:0] pump_current_select_out,
    input wire logic [1:0] duty_cycle_loop_mode_out,
    input wire logic       receive_enable_out,
    input wire logic       transmit_enable_out,
    input wire logic       synth_dividers_enable_out,
    input wire logic       phase_detector_reset_out,
    input wire logic       pump_current_ref_connect_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // eight settled cycles cover the ~5 cycle pin filter
    sequence s_strobe_high; ser_strobe_in [*8]; endsequence
    sequence s_strobe_low; !ser_strobe_in [*8]; endsequence
    sequence s_synth_off; !synth_power_on_in [*8]; endsequence
    sequence s_synth_on; synth_power_on_in [*8]; endsequence

    AST_RX_ON: assert property (receive_power_on_in [*8] |-> receive_enable_out)
        else $error("receiver not enabled");
    AST_RX_OFF: assert property (!receive_power_on_in [*8] |-> !receive_enable_out)
        else $error("receiver enabled while pin low");
    AST_TX_ON: assert property (!transmit_power_down_n_in [*8]
        |-> transmit_enable_out)
        else $error("transmitter not enabled");
    AST_TX_OFF: assert property (transmit_power_down_n_in [*8]
        |-> !transmit_enable_out)
        else $error("transmitter enabled while pin high");
    AST_SYN_OFF: assert property (s_synth_off |-> !synth_dividers_enable_out
        && phase_detector_reset_out && !pump_current_ref_connect_out)
        else $error("synthesizer not powered down");
    AST_SYN_ON: assert property (s_synth_on |-> synth_dividers_enable_out
        && !phase_detector_reset_out && pump_current_ref_connect_out)
        else $error("synthesizer not powered up");
    AST_SYN_ROSE: assert property ($rose(synth_dividers_enable_out)
        |-> $past(synth_power_on_in, 3))
        else $error("dividers enabled without pin");
    // commit lands within about 5 cycles of the strobe rise, so later cycles are quiet
    AST_HOLD_HIGH: assert property (s_strobe_high |=> $stable({pin_a_level_out,
        pin_b_level_out, main_divider_ratio_out, pump_current_select_out,
        duty_cycle_loop_mode_out}))
        else $error("outputs moved while strobe high");
    AST_HOLD_LOW: assert property (s_strobe_low |=> $stable({pin_a_level_out,
        pin_b_level_out, main_divider_ratio_out, pump_current_select_out,
        duty_cycle_loop_mode_out}))
        else $error("outputs moved while shifting");
    AST_RATIO_MIN: assert property (main_divider_ratio_out >= iftcr_pkg::RATIO_MIN)
        else $error("main ratio below minimum");
endmodule : iftcr_ctrl_regs_assertions

bind iftcr_ctrl_regs iftcr_ctrl_regs_assertions i_chk (.*);

// file: tb/iftcr_serial_host.sv
/*
 * Baseband controller model: drives the three-wire serial programming pins.
 * Assumes a 125 ns serial clock that stands low outside frames.
 */
`timescale 1ns/1ns

module iftcr_serial_host (
    // serial pins
    output logic ser_clock_out,
    output logic ser_strobe_out,
    output logic ser_data_out
);
    // strobe low from power-up so the reset is clean
    initial begin
        ser_clock_out = 1'b0;
        ser_strobe_out = 1'b0;
        ser_data_out = 1'b0;
    end

    // 21 bits msb first; lower=0 clocks with strobe high on purpose
    task automatic shift(input logic [20:0] w, input bit lower);
        if (lower) begin
            ser_strobe_out = 1'b0;
            #125;
        end
        for (int k = 20; k >= 0; k--) begin
            ser_data_out = w[k];
            #62 ser_clock_out = 1'b1;
            #63 ser_clock_out = 1'b0;
        end
        ser_data_out = ~ser_data_out; // a released line must not show the last bit
    endtask : shift

    // strobe rise after the clock-to-strobe setup, then held high
    task automatic commit;
        #125 ser_strobe_out = 1'b1;
        #250;
    endtask : commit

    task automatic send(input logic [20:0] w);
        shift(w, 1'b1);
        commit();
    endtask : send

    // strobe pulse with no clocks: recommits whatever the shift register holds
    task automatic restrobe;
        ser_strobe_out = 1'b0;
        #250;
        commit();
    endtask : restrobe
endmodule : iftcr_serial_host

// file: tb/tb_iftcr_ctrl_regs.sv
/*
 * Self-checking testbench for iftcr_ctrl_regs with a serial controller model.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ns

module tb_iftcr_ctrl_regs;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ser_clock_in, ser_strobe_in, ser_data_in;
    logic receive_power_on_in = 1'b0;
    logic transmit_power_down_n_in = 1'b1;
    logic synth_power_on_in = 1'b1;
    logic pin_a_level_out, pin_b_level_out, inphase_trim_polarity_out, quad_trim_polarity_out;
    logic if_atten_select_out, factory_test_bit_out, rc_cutoff_select_out;
    logic gyrator_resistor_select_out, receive_enable_out, transmit_enable_out;
    logic synth_dividers_enable_out, phase_detector_reset_out, pump_current_ref_connect_out;
    logic [8:0] main_divider_ratio_out;
    logic [2:0] pump_current_select_out, inphase_trim_magnitude_out, quad_trim_magnitude_out;
    logic [1:0] reference_divide_select_out, lock_pin_test_select_out, duty_cycle_loop_mode_out;
    int failures = 0;
    int checks = 0;

    iftcr_ctrl_regs i_dut (.*);
    iftcr_serial_host i_host (.ser_clock_out(ser_clock_in), .ser_strobe_out(ser_strobe_in),
                              .ser_data_out(ser_data_in));

    always #5 clk_in = ~clk_in;

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : wait_cyc

    // word builders in shift order; pump bits go out weight-1 first
    function automatic logic [20:0] w0(logic [8:0] n, logic [1:0] r, logic [2:0] p,
                                       logic [1:0] x);
        return {iftcr_pkg::CHIP_ADDR, iftcr_pkg::SEL_SYNTH, n, r, p[0], p[1], p[2], x};
    endfunction : w0

    task automatic chk_w0(input logic [8:0] n, input logic [1:0] r, input logic [2:0] p,
                          input logic [1:0] x);
        chk(main_divider_ratio_out, n);
        chk(reference_divide_select_out, r);
        chk(pump_current_select_out, p);
        chk(lock_pin_test_select_out, x);
    endtask : chk_w0

    task automatic t_reset;
        chk_w0(iftcr_pkg::RATIO_RST, iftcr_pkg::REF_RST, iftcr_pkg::PUMP_RST, 2'h0);
        chk({pin_a_level_out, pin_b_level_out}, iftcr_pkg::PINS_RST);
        chk({if_atten_select_out, duty_cycle_loop_mode_out,
             quad_trim_magnitude_out}, 9'h0);
    endtask : t_reset

    // full-scale ratio, then the minimum ratio loaded with the synthesizer off
    task automatic t_word0;
        i_host.send(w0(9'h1ff, 2'h2, 3'h1, 2'h1));
        wait_cyc(8);
        chk_w0(9'h1ff, 2'h2, 3'h1, 2'h1);
        @(posedge clk_in) #1 synth_power_on_in = 1'b0;
        i_host.send(w0(9'h040, 2'h1, 3'h6, 2'h2));
        wait_cyc(8);
        chk_w0(9'h040, 2'h1, 3'h6, 2'h2);
        chk({synth_dividers_enable_out, phase_detector_reset_out}, 9'h1);
        @(posedge clk_in) #1 synth_power_on_in = 1'b1;
    endtask : t_word0

    // clocks under a high strobe must not reach the shift register
    task automatic t_strobe_high;
        i_host.shift(w0(9'h0aa, 2'h3, 3'h2, 2'h3), 1'b0);
        i_host.restrobe();
        wait_cyc(8);
        chk_w0(9'h040, 2'h1, 3'h6, 2'h2);
    endtask : t_strobe_high

    task automatic t_bad_addr;
        logic [20:0] w;
        w = w0(9'h155, 2'h3, 3'h5, 2'h3);
        w[20:17] = 4'hd;
        i_host.send(w);
        wait_cyc(8);
        chk_w0(9'h040, 2'h1, 3'h6, 2'h2);
    endtask : t_bad_addr

    // every duty-cycle loop mode, with pins, trims and the other mode bits except the factory test bit varied alongside
    task automatic t_word1;
        logic [1:0] m;
        logic [3:0] q, i;
        for (int k = 0; k < 4; k++) begin
            m = 2'(k);
            q = {m[0], 3'(k + 1)};
            i = {~m[1], 3'(7 - k)};
            i_host.send({iftcr_pkg::CHIP_ADDR, iftcr_pkg::SEL_RECEIVE, m, q, i,
                         m[0], 1'b0, m, m[1], ~m[0]});
            wait_cyc(8);
            chk({pin_a_level_out, pin_b_level_out}, m);
            chk({quad_trim_polarity_out, quad_trim_magnitude_out}, q);
            chk({inphase_trim_polarity_out, inphase_trim_magnitude_out}, i);
            chk({if_atten_select_out, factory_test_bit_out}, {m[0], 1'b0});
            chk(duty_cycle_loop_mode_out, m);
            chk({rc_cutoff_select_out, gyrator_resistor_select_out}, {m[1], ~m[0]});
        end
    endtask : t_word1

    // pin sets with the synthesizer off while receive or transmit is on are skipped
    task automatic t_power;
        for (int k = 1; k < 8; k++) begin
            if (!k[0] && (k[2] || !k[1])) continue;
            @(posedge clk_in) #1 {receive_power_on_in, transmit_power_down_n_in,
                                  synth_power_on_in} = 3'(k);
            wait_cyc(10);
            chk({receive_enable_out, transmit_enable_out}, {k[2], ~k[1]});
            chk({synth_dividers_enable_out, pump_current_ref_connect_out,
                 phase_detector_reset_out}, {k[0], k[0], ~k[0]});
        end
    endtask : t_power

    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report

    // about 8 words of 300 cycles each; the limit leaves a wide margin
    initial begin
        #200000;
        failures++;
        final_report();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        // two edges after release the section enables must still read off
        wait_cyc(2);
        chk({receive_enable_out, transmit_enable_out}, 9'h0);
        wait_cyc(8);
        t_reset();
        t_word0();
        t_strobe_high();
        t_bad_addr();
        t_word1();
        t_power();
        final_report();
    end
endmodule : tb_iftcr_ctrl_regs
